// >>> rcfe_ctl_model.sv
// controller model: takes reply bytes from the front end, fast or slow
// assumes the ob_* handshake of rcfe_top and the same single clock
`timescale 1ns/10ps
module rcfe_ctl_model (
  input wire logic sys_clk, // clock
  input wire logic nrst, // synchronous reset, active low
  input wire logic slow, // take a byte only every other cycle
  input wire logic clr, // forget what was taken
  input wire logic [7:0] ob_data, // reply byte
  input wire logic ob_valid, // reply byte present
  input wire logic ob_eoi, // end-or-identify with byte
  output logic ob_ready, // byte taken on this edge
  output logic [7:0] rx [0:79], // bytes taken in order
  output logic [7:0] rx_n, // count taken
  output logic rx_eoi // eoi seen with the last byte
);
  always @(posedge sys_clk) begin
    if (!nrst || clr) begin
      rx_n <= 8'h00;
      rx_eoi <= 1'b0;
      ob_ready <= 1'b0;
    end else begin
      // slow mode toggles ready so the block must hold its byte
      ob_ready <= slow ? ~ob_ready : 1'b1;
      if (ob_valid && ob_ready) begin
        rx[rx_n] <= ob_data;
        rx_n <= rx_n + 8'h01;
        rx_eoi <= ob_eoi;
      end
    end
  end
endmodule : rcfe_ctl_model

// >>> rcfe_pkg.sv
// constants, encodings and helper functions for the remote command front end
// assumes one 200 MHz clock; shared by the design and its verification files
package rcfe_pkg;

  // register index map on the plain register port
  localparam logic [3:0] REG_MODE = 4'h0;
  localparam logic [3:0] REG_CMD = 4'h1;
  localparam logic [3:0] REG_REJ = 4'h2;
  localparam logic [3:0] REG_LOC = 4'h3;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam logic [3:0] REG_FLDV = 4'h5;
  localparam logic [3:0] REG_FLDC = 4'h6;
  localparam logic [3:0] REG_FLDO = 4'h7;
  localparam logic [3:0] REG_FLDM = 4'h8;

  // interface mode bits, ordered by weight 1,2,4,8,16
  localparam int MB_TERM = 0;
  localparam int MB_REC = 1;
  localparam int MB_VALID = 2;
  localparam int MB_UNBUF = 3;
  localparam int MB_ERR = 4;
  localparam logic [4:0] MODE_RST = 5'h00;

  // command register bits
  localparam int CB_OBUF = 0;
  localparam int CB_REJ = 1;
  localparam int CB_ICLR = 2;
  localparam int CB_LRD = 3;
  localparam int CB_MQRY = 4;

  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_SEMI = 8'h3b;
  localparam logic [7:0] CH_COMMA = 8'h2c;
  localparam logic [7:0] CH_A = 8'h41;
  localparam logic [7:0] CH_M = 8'h4d;
  localparam logic [7:0] CH_P = 8'h50;
  localparam logic [7:0] CH_0 = 8'h30;

  localparam logic [6:0] IBUF_DEPTH = 7'h50;
  localparam logic [4:0] CK_IDX = 5'h1f;
  localparam logic [6:0] LL_CK_CHR = 7'h3f;
  localparam logic [6:0] LL_LAST_CHR = 7'h41;
  localparam logic [6:0] LOC_LIVE = 7'h63;
  localparam logic [6:0] LOC_PRESET = 7'h62;
  localparam logic [7:0] CKSUM_TARGET = 8'h01;
  localparam int LRN_REJ_BIT = 7;

  localparam int SETTLE_MS = 45;
  localparam int CLK_KHZ = 200000;
  localparam int SETTLE_CYC_DEF = SETTLE_MS * CLK_KHZ;

  localparam logic [1:0] FK_AMPL = 2'h1;
  localparam logic [1:0] FK_DEV = 2'h2;
  localparam logic [2:0] U_NONE = 3'h0;
  localparam logic [2:0] U_DB10 = 3'h1;
  localparam logic [2:0] U_NV = 3'h2;
  localparam logic [2:0] U_HZ = 3'h3;
  localparam logic [2:0] U_RAD = 3'h4;

  function automatic logic [7:0] nib2chr(input logic [3:0] nib);
    nib2chr = CH_A + {4'h0, nib};
  endfunction : nib2chr

  function automatic logic [3:0] chr2nib(input logic [7:0] c);
    logic [7:0] d;
    d = c - CH_A;
    chr2nib = d[3:0];
  endfunction : chr2nib

  function automatic logic is_lrn(input logic [7:0] c);
    is_lrn = (c >= CH_A) && (c <= CH_P);
  endfunction : is_lrn

endpackage : rcfe_pkg

// >>> rcfe_tb_top.sv
// self-checking bench for the remote command front end
// assumes rcfe_top, rcfe_ctl_model and one 200 MHz clock
`timescale 1ns/10ps
module rcfe_tb_top;
  localparam int SC = 20;
  logic sys_clk, nrst, reg_wr, reg_rd, ib_valid, ib_eoi, ib_ready, dev_clr, pr_valid, pr_last;
  logic pr_ready, pr_start, pr_done, hw_change, rf_valid, ob_valid, ob_eoi, ob_ready, lrn_we;
  logic preset_recall, comp_abort, slow, clr, rx_eoi, saw_rc, saw_ab, ll_start, ll_valid;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, d;
  logic [7:0] ib_data, pr_data, rej_set, ob_data, lrn_rdata, lrn_wdata, rx_n, ll_char, lastc;
  logic [7:0] rx [0:79];
  logic [6:0] lrn_loc, recall_loc;
  logic [4:0] lrn_raddr, lrn_waddr;
  logic [4:0] rows [7] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h13, 5'h1f};
  // field rows: raw value, control, signed value, meta
  logic [63:0] frows [4] = '{64'hff9c_031a_ff9c_0201, 64'h001e_0129_001e_0314,
    64'h00c8_0196_ffc8_0062, 64'h0005_00e3_0005_0233};
  int fail_count = 0, checked = 0, starts = 0, nch = 0, nwe = 0;
  rcfe_top #(.SETTLE_CYC(SC)) DUT (.sys_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .ib_data, .ib_valid, .ib_eoi, .ib_ready, .dev_clr, .pr_data, .pr_valid,
    .pr_last, .pr_ready, .pr_start, .pr_done, .rej_set, .hw_change, .rf_valid, .ob_data,
    .ob_valid, .ob_eoi, .ob_ready, .lrn_loc, .lrn_raddr, .lrn_rdata, .cur_status(8'h5a),
    .ll_start, .ll_char, .ll_valid, .lrn_we, .lrn_waddr, .lrn_wdata,
    .preset_recall, .recall_loc, .comp_abort);
  rcfe_ctl_model ctl (.sys_clk, .nrst, .slow, .clr, .ob_data, .ob_valid, .ob_eoi, .ob_ready,
    .rx, .rx_n, .rx_eoi);
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // learn store answers with its own index; processor takes each char at once unless pr_ready is held low
  always @(posedge sys_clk) begin
    lrn_rdata <= {3'h0, lrn_raddr};
    pr_done <= pr_valid && pr_ready && pr_last;
    if (pr_start) starts <= starts + 1;
    if (pr_valid && pr_ready) {nch, lastc} <= {nch + 1, pr_data};
    if (lrn_we) nwe <= nwe + 1;
    if (preset_recall) saw_rc <= 1'b1;
    if (comp_abort) saw_ab <= 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    if (fail_count == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic pulse_in(input logic [7:0] r, input logic h, input logic c);
    @(posedge sys_clk);
    {rej_set, hw_change, dev_clr, clr} <= {r, h, c, c};
    @(posedge sys_clk);
    {rej_set, hw_change, dev_clr, clr} <= '0;
  endtask : pulse_in
  task automatic waitn(input logic [7:0] n);
    for (int k = 0; k < 2000 && rx_n != n; k++) @(posedge sys_clk);
    #1 chk("reply count", n, rx_n);
  endtask : waitn
  task automatic snd(input logic [7:0] b, input logic e);
    @(posedge sys_clk);
    {ib_data, ib_eoi, ib_valid} <= {b, e, 1'b1};
    #1;
    for (int k = 0; k < 300 && ib_ready !== 1'b1; k++) @(posedge sys_clk) #1;
    @(posedge sys_clk);
    ib_valid <= 1'b0;
  endtask : snd
  task automatic unit(input logic [15:0] m, input string s, input logic e, input int u);
    wr(rcfe_pkg::REG_MODE, m);
    starts = 0;
    nch = 0;
    for (int k = 0; k < s.len(); k++) snd(s[k], e && k == s.len() - 1);
    for (int k = 0; k < 300 && nch != s.len(); k++) @(posedge sys_clk);
    #1 chk("units", u, starts);
    chk("chars", s.len(), nch);
    chk("last char", s[s.len() - 1], lastc);
  endtask : unit
  // 31 data bytes of value index/2, checksum ck, two non-letter status chars
  task automatic lload(input logic [7:0] ck);
    logic [7:0] b;
    @(posedge sys_clk);
    ll_start <= 1'b1;
    for (int k = 0; k < 66; k++) begin
      b = (k > 61) ? ck : 8'(k / 2);
      @(posedge sys_clk);
      {ll_start, ll_valid} <= 2'b01;
      ll_char <= (k > 63) ? 8'h30 : 8'h41 + {4'h0, k[0] ? b[3:0] : b[7:4]};
    end
    @(posedge sys_clk);
    ll_valid <= 1'b0;
  endtask : lload
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {nrst, reg_wr, reg_rd, ib_valid, ib_eoi, dev_clr, hw_change, slow, clr, saw_rc, saw_ab} = '0;
    {reg_addr, reg_wdata, ib_data, rej_set, ll_char, ll_start, ll_valid} = '0;
    pr_ready = 1'b1;
    repeat (8) @(posedge sys_clk);
    nrst <= 1'b1;
    #1 chk("ib_ready", 1, ib_ready);
    chk("rf_valid", 1, rf_valid);
    chk("ob_valid", 0, ob_valid);
    wr(rcfe_pkg::REG_CMD, 16'h0001);
    rd(4'hf);
    chk("unmapped", 0, d);
    foreach (rows[i]) begin
      wr(rcfe_pkg::REG_MODE, {11'h000, rows[i]});
      rd(rcfe_pkg::REG_MODE);
      chk("mode", {11'h000, rows[i]}, d);
      pulse_in(8'h00, 1'b0, 1'b0);
      clr <= 1'b1;
      wr(rcfe_pkg::REG_CMD, 16'h0010);
      clr <= 1'b0;
      waitn(6);
      chk("q lead", 8'h30, rx[2]);
      chk("q tens", 8'h30 + rows[i] / 5'h0a, rx[3]);
      chk("q ones", 8'h30 + rows[i] % 5'h0a, rx[4]);
      chk("q term", rows[i][0] ? 8'h0d : 8'h0a, rx[5]);
      chk("q eoi", 1, rx_eoi);
    end
    foreach (frows[i]) begin
      wr(rcfe_pkg::REG_FLDV, frows[i][63:48]);
      wr(rcfe_pkg::REG_FLDC, frows[i][47:32]);
      rd(rcfe_pkg::REG_FLDO);
      chk("fld value", frows[i][31:16], d);
      rd(rcfe_pkg::REG_FLDM);
      chk("fld meta", frows[i][15:0], d);
    end
    wr(rcfe_pkg::REG_MODE, 16'h0000);
    for (int j = 0; j < 2; j++) begin
      slow <= (j == 1);
      wr(rcfe_pkg::REG_LOC, j ? 16'h0063 : 16'h0000);
      #1 chk("lrn loc", j ? 16'h0063 : 16'h0000, lrn_loc);
      clr <= 1'b1;
      wr(rcfe_pkg::REG_CMD, 16'h0008);
      clr <= 1'b0;
      waitn(67);
      for (int i = 0; i < 31; i++) begin
        chk("lrn hi", 8'h41 + i / 16, rx[2 * i]);
        chk("lrn lo", 8'h41 + i % 16, rx[2 * i + 1]);
      end
      chk("ck hi", 8'h44, rx[62]);
      chk("ck lo", 8'h41, rx[63]);
      chk("st hi", j ? 8'h46 : 8'h41, rx[64]);
      chk("st lo", j ? 8'h4b : 8'h4d, rx[65]);
      chk("lrn term", 8'h0a, rx[66]);
    end
    wr(rcfe_pkg::REG_CMD, 16'h0008);
    repeat (10) @(posedge sys_clk);
    wr(rcfe_pkg::REG_CMD, 16'h0001);
    repeat (3) @(posedge sys_clk);
    #1 chk("ob clear", 0, ob_valid);
    pulse_in(8'h05, 1'b0, 1'b0);
    rd(rcfe_pkg::REG_REJ);
    chk("rej", 16'h0005, d);
    rd(rcfe_pkg::REG_REJ);
    chk("rej read", 0, d);
    pulse_in(8'h06, 1'b0, 1'b0);
    wr(rcfe_pkg::REG_CMD, 16'h0002);
    rd(rcfe_pkg::REG_REJ);
    chk("rej cmd", 0, d);
    wr(rcfe_pkg::REG_MODE, 16'h001f);
    pulse_in(8'h03, 1'b0, 1'b0);
    wr(rcfe_pkg::REG_CMD, 16'h0004);
    rd(rcfe_pkg::REG_MODE);
    chk("iclr mode", 0, d);
    rd(rcfe_pkg::REG_REJ);
    chk("iclr rej", 0, d);
    chk("recall loc", 7'h62, recall_loc);
    chk("recall", 1, saw_rc & saw_ab);
    unit(16'h0000, "A;B\n", 1'b0, 2);
    unit(16'h0002, "A;B\n", 1'b0, 1);
    unit(16'h0002, "AB", 1'b1, 1);
    pulse_in(8'h09, 1'b0, 1'b0);
    unit(16'h0010, "A;", 1'b0, 1);
    rd(rcfe_pkg::REG_REJ);
    chk("err mode", 0, d);
    pulse_in(8'h09, 1'b0, 1'b0);
    unit(16'h0000, "A;", 1'b0, 1);
    rd(rcfe_pkg::REG_REJ);
    chk("err off", 16'h0009, d);
    wr(rcfe_pkg::REG_MODE, 16'h0004);
    pulse_in(8'h00, 1'b1, 1'b0);
    starts = 0;
    snd(8'h41, 1'b0);
    snd(8'h3b, 1'b0);
    #1 chk("settling", 0, rf_valid);
    chk("gated", 0, starts);
    repeat (SC + 10) @(posedge sys_clk);
    #1 chk("settled", 1, starts);
    // stalled processor lets the held input be seen at the handshake
    pr_ready <= 1'b0;
    wr(rcfe_pkg::REG_MODE, 16'h0008);
    {starts, nch} = '0;
    snd(8'h41, 1'b0);
    snd(8'h3b, 1'b0);
    repeat (4) @(posedge sys_clk);
    #1 chk("unbuf hold", 0, ib_ready);
    chk("unbuf start", 1, starts);
    chk("unbuf stall", 0, nch);
    pr_ready <= 1'b1;
    repeat (20) @(posedge sys_clk);
    #1 chk("unbuf chars", 2, nch);
    pr_ready <= 1'b0;
    wr(rcfe_pkg::REG_MODE, 16'h0010);
    pulse_in(8'h03, 1'b0, 1'b0);
    for (int k = 0; k < 80; k++) snd(8'h41, 1'b0);
    #1 chk("buf full", 0, ib_ready);
    pulse_in(8'h00, 1'b0, 1'b1);
    repeat (3) @(posedge sys_clk);
    #1 chk("in clear", 1, ib_ready);
    rd(rcfe_pkg::REG_REJ);
    chk("bus clr rej", 0, d);
    lload(8'h30);
    rd(rcfe_pkg::REG_REJ);
    chk("ll ok", 0, d);
    chk("ll writes", 32, nwe);
    chk("ll byte", 8'h30, lrn_wdata);
    chk("ll index", 5'h1f, lrn_waddr);
    lload(8'h31);
    rd(rcfe_pkg::REG_REJ);
    chk("ll bad sum", 16'h0080, d);
    wrap_up();
  end
  initial begin
    repeat (40000) @(posedge sys_clk);
    fail_count++;
    wrap_up();
  end
endmodule : rcfe_tb_top

// >>> rcfe_top.sv
// remote command front end: input framing, interface modes, clears,
// rejected status, settle gating, learn string encode and decode
// assumes a same-clock bus handshake engine, command processor and learn store
`timescale 1ns/10ps
module rcfe_top #(
  parameter int SETTLE_CYC = rcfe_pkg::SETTLE_CYC_DEF
) (
  input wire logic sys_clk, // 200 MHz clock
  input wire logic nrst, // synchronous reset, active low
  input wire logic [3:0] reg_addr, // register index
  input wire logic [15:0] reg_wdata, // register write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [15:0] reg_rdata, // read data, cycle after strobe
  input wire logic [7:0] ib_data, // received bus byte
  input wire logic ib_valid, // received byte present
  input wire logic ib_eoi, // end-or-identify with byte
  output logic ib_ready, // handshake permit for received byte
  input wire logic dev_clr, // SDC or DCL pulse
  output logic [7:0] pr_data, // character to processor
  output logic pr_valid, // character present
  output logic pr_last, // last character of message unit
  input wire logic pr_ready, // processor takes character
  output logic pr_start, // message unit begins
  input wire logic pr_done, // processor finished unit
  input wire logic [7:0] rej_set, // rejected entry codes to set
  input wire logic hw_change, // hardware setting changed
  output logic rf_valid, // output settled
  output logic [7:0] ob_data, // reply byte
  output logic ob_valid, // reply byte present
  output logic ob_eoi, // end-or-identify with reply byte
  input wire logic ob_ready, // bus takes reply byte
  output logic [6:0] lrn_loc, // learn location code
  output logic [4:0] lrn_raddr, // learn image byte index
  input wire logic [7:0] lrn_rdata, // learn byte, cycle after index
  input wire logic [7:0] cur_status, // live current-state byte
  input wire logic ll_start, // learn load begins
  input wire logic [7:0] ll_char, // learn load character
  input wire logic ll_valid, // learn load character present
  output logic lrn_we, // learn image write
  output logic [4:0] lrn_waddr, // learn image write index
  output logic [7:0] lrn_wdata, // learn image write byte
  output logic preset_recall, // recall pulse
  output logic [6:0] recall_loc, // location to recall
  output logic comp_abort // abort compensation, drop its data
);

  typedef enum logic [2:0] {
    P_IDLE = 3'h1, P_RUN = 3'h2, P_WAIT = 3'h4
  } rcfe_pst_t;

  typedef enum logic [6:0] {
    O_IDLE = 7'h01, O_FETCH = 7'h02, O_HI = 7'h04, O_LO = 7'h08,
    O_STAT = 7'h10, O_QRY = 7'h20, O_TERM = 7'h40
  } rcfe_ost_t;

  typedef struct packed {
    logic [4:0] mode;
    logic [7:0] rej;
    logic [6:0] loc;
    logic [15:0] fldv;
    logic [9:0] fldc;
    logic [15:0] rd;
    logic [rcfe_pkg::IBUF_DEPTH-1:0][8:0] mem;
    logic [6:0] wp;
    logic [6:0] rp;
    logic [6:0] cnt;
    logic [6:0] units;
    logic ibr;
    rcfe_pst_t pst;
    logic [7:0] prd;
    logic prv;
    logic prl;
    logic prs;
    logic [23:0] settle;
    logic rfv;
    rcfe_ost_t ost;
    logic [4:0] bi;
    logic [2:0] idx;
    logic [3:0] lo;
    logic [7:0] sum;
    logic [7:0] obd;
    logic obv;
    logic obe;
    logic [6:0] li;
    logic [7:0] lsum;
    logic [3:0] lhi;
    logic lwe;
    logic [4:0] lwa;
    logic [7:0] lwd;
    logic rcl;
    logic [6:0] rloc;
    logic cab;
  } rcfe_state_t;

  rcfe_state_t s, n;

  function automatic logic [6:0] ptr_inc(input logic [6:0] p);
    ptr_inc = (p == rcfe_pkg::IBUF_DEPTH - 7'h01) ? 7'h00 : p + 7'h01;
  endfunction : ptr_inc

  // {meta, value}; meta = used, milli, exponent, unit
  function automatic logic [31:0] fdec(input logic [15:0] v, input logic [9:0] c);
    logic [16:0] full;
    logic [16:0] span;
    logic [16:0] val;
    logic [3:0] top;
    logic [3:0] res;
    logic [2:0] unit;
    logic [3:0] expo;
    logic milli;
    res = c[3:0];
    case (c[9:8])
      2'h0: begin top = v[3:0]; full = {13'h0, v[3:0]}; span = 17'h00010; end
      2'h1: begin top = v[7:4]; full = {9'h0, v[7:0]}; span = 17'h00100; end
      2'h2: begin top = v[11:8]; full = {5'h0, v[11:0]}; span = 17'h01000; end
      default: begin top = v[15:12]; full = {1'h0, v}; span = 17'h10000; end
    endcase
    val = top[3] ? full - span : full;
    unit = rcfe_pkg::U_NONE;
    expo = 4'h0;
    milli = 1'b0;
    if (c[5:4] == rcfe_pkg::FK_AMPL) begin
      if (res == 4'ha || res == 4'hb) begin
        unit = rcfe_pkg::U_DB10;
      end else if (res <= 4'h9) begin
        unit = rcfe_pkg::U_NV;
        expo = res;
      end
    end else if (c[5:4] == rcfe_pkg::FK_DEV) begin
      expo = {1'b0, res[2:0]};
      unit = res[3] ? rcfe_pkg::U_RAD : rcfe_pkg::U_HZ;
      milli = res[3];
    end
    // reference fields count only with their relative mode on
    fdec = {6'h0, (!c[7] || c[6]), milli, expo, 1'b0, unit, val[15:0]};
  endfunction : fdec

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic wr_cmd;
    logic iclr;
    logic obclr;
    logic push;
    logic pop;
    logic took;
    logic delim;
    logic ofree;
    logic lerr;
    logic rejclr;
    logic live;
    logic [7:0] term;
    logic [7:0] byt;
    logic [7:0] tens;
    logic [7:0] ones;
    logic [3:0] nib;
    logic [31:0] fo;
    n = s;
    n.prs = 1'b0;
    n.lwe = 1'b0;
    n.rcl = 1'b0;
    n.cab = 1'b0;
    n.rd = 16'h0000;
    wr_cmd = reg_wr && (reg_addr == rcfe_pkg::REG_CMD);
    iclr = (wr_cmd && reg_wdata[rcfe_pkg::CB_ICLR]) || dev_clr;
    obclr = iclr || (wr_cmd && reg_wdata[rcfe_pkg::CB_OBUF]);
    rejclr = iclr || (wr_cmd && reg_wdata[rcfe_pkg::CB_REJ]);
    term = s.mode[rcfe_pkg::MB_TERM] ? rcfe_pkg::CH_CR : rcfe_pkg::CH_LF;
    live = (s.loc == rcfe_pkg::LOC_LIVE);
    ofree = !s.obv || ob_ready;
    lerr = 1'b0;
    fo = fdec(s.fldv, s.fldc);
    tens = (s.mode >= 5'h1e) ? 8'h03 : (s.mode >= 5'h14) ? 8'h02 :
           (s.mode >= 5'h0a) ? 8'h01 : 8'h00;
    ones = {3'h0, s.mode} - tens * 8'h0a;
    nib = rcfe_pkg::chr2nib(ll_char);
    byt = 8'h00;

    // register port
    if (reg_wr) begin
      case (reg_addr)
        rcfe_pkg::REG_MODE: n.mode = reg_wdata[4:0];
        rcfe_pkg::REG_LOC: n.loc = reg_wdata[6:0];
        rcfe_pkg::REG_FLDV: n.fldv = reg_wdata;
        rcfe_pkg::REG_FLDC: n.fldc = reg_wdata[9:0];
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        rcfe_pkg::REG_MODE: n.rd = {11'h0, s.mode};
        rcfe_pkg::REG_REJ: n.rd = {8'h00, s.rej};
        rcfe_pkg::REG_LOC: n.rd = {9'h0, s.loc};
        rcfe_pkg::REG_STAT: n.rd = {s.pst != P_IDLE, s.rfv, s.units, s.cnt};
        rcfe_pkg::REG_FLDV: n.rd = s.fldv;
        rcfe_pkg::REG_FLDC: n.rd = {6'h0, s.fldc};
        rcfe_pkg::REG_FLDO: n.rd = fo[15:0];
        rcfe_pkg::REG_FLDM: n.rd = fo[31:16];
        default: n.rd = 16'h0000;
      endcase
      if (reg_addr == rcfe_pkg::REG_REJ) begin
        rejclr = 1'b1;
      end
    end

    // output settling
    if (hw_change) begin
      n.settle = SETTLE_CYC[23:0];
    end else if (s.settle != 24'h000000) begin
      n.settle = s.settle - 24'h000001;
    end
    n.rfv = (n.settle == 24'h000000);

    // input buffer fill
    push = ib_valid && s.ibr;
    delim = ib_eoi || (ib_data == term) ||
            (!s.mode[rcfe_pkg::MB_REC] &&
             (ib_data == rcfe_pkg::CH_SEMI || ib_data == rcfe_pkg::CH_COMMA));
    if (push) begin
      n.mem[s.wp] = {delim, ib_data};
      n.wp = ptr_inc(s.wp);
    end

    // message unit hand-off to the processor
    pop = 1'b0;
    took = 1'b0;
    case (s.pst)
      P_IDLE: begin
        // only whole units start; valid mode waits for settling
        if (s.units != 7'h00 && (!s.mode[rcfe_pkg::MB_VALID] || s.rfv)) begin
          n.pst = P_RUN;
          n.prs = 1'b1;
          if (s.mode[rcfe_pkg::MB_ERR]) begin
            rejclr = 1'b1;
          end
        end
      end
      P_RUN: begin
        if (s.prv && pr_ready) begin
          n.prv = 1'b0;
          took = s.prl;
          if (s.prl) begin
            n.pst = P_WAIT;
          end
        end else if (!s.prv && s.cnt != 7'h00) begin
          pop = 1'b1;
          n.prd = s.mem[s.rp][7:0];
          n.prl = s.mem[s.rp][8];
          n.prv = 1'b1;
          n.rp = ptr_inc(s.rp);
        end
      end
      P_WAIT: begin
        if (pr_done) begin
          n.pst = P_IDLE;
        end
      end
      default: n.pst = P_IDLE;
    endcase
    n.cnt = s.cnt + {6'h00, push} - {6'h00, pop};
    n.units = s.units + {6'h00, push && delim} - {6'h00, took};

    // learn load decode
    if (ll_start) begin
      n.li = 7'h00;
      n.lsum = 8'h00;
    end else if (ll_valid && s.li <= rcfe_pkg::LL_LAST_CHR) begin
      n.li = s.li + 7'h01;
      // status characters are ignored on load
      if (s.li <= rcfe_pkg::LL_CK_CHR) begin
        if (!rcfe_pkg::is_lrn(ll_char)) begin
          lerr = 1'b1;
        end
        if (!s.li[0]) begin
          n.lhi = nib;
        end else begin
          byt = {s.lhi, nib};
          n.lwe = 1'b1;
          n.lwa = s.li[5:1];
          n.lwd = byt;
          n.lsum = s.lsum + byt;
          if (s.li == rcfe_pkg::LL_CK_CHR && n.lsum != rcfe_pkg::CKSUM_TARGET) begin
            lerr = 1'b1;
          end
        end
      end
    end

    // reply sequencer
    if (s.obv && ob_ready) begin
      n.obv = 1'b0;
      n.obe = 1'b0;
    end
    case (s.ost)
      O_IDLE: begin
        if (wr_cmd && reg_wdata[rcfe_pkg::CB_LRD]) begin
          n.bi = 5'h00;
          n.sum = 8'h00;
          n.ost = O_FETCH;
        end else if (wr_cmd && reg_wdata[rcfe_pkg::CB_MQRY]) begin
          n.idx = 3'h0;
          n.ost = O_QRY;
        end
      end
      O_FETCH: n.ost = O_HI;
      O_HI: begin
        if (ofree) begin
          byt = (s.bi == rcfe_pkg::CK_IDX) ? rcfe_pkg::CKSUM_TARGET - s.sum : lrn_rdata;
          n.obd = rcfe_pkg::nib2chr(byt[7:4]);
          n.obv = 1'b1;
          n.lo = byt[3:0];
          n.sum = s.sum + byt;
          n.ost = O_LO;
        end
      end
      O_LO: begin
        if (ofree) begin
          n.obd = rcfe_pkg::nib2chr(s.lo);
          n.obv = 1'b1;
          n.idx = 3'h0;
          n.bi = s.bi + 5'h01;
          n.ost = (s.bi == rcfe_pkg::CK_IDX) ? O_STAT : O_FETCH;
        end
      end
      O_STAT: begin
        if (ofree) begin
          n.obv = 1'b1;
          n.idx = s.idx + 3'h1;
          if (s.idx == 3'h0) begin
            n.obd = live ? rcfe_pkg::nib2chr(cur_status[7:4]) : rcfe_pkg::CH_A;
          end else begin
            n.obd = live ? rcfe_pkg::nib2chr(cur_status[3:0]) : rcfe_pkg::CH_M;
            n.ost = O_TERM;
          end
        end
      end
      O_QRY: begin
        if (ofree) begin
          n.obv = 1'b1;
          n.idx = s.idx + 3'h1;
          n.obd = (s.idx == 3'h3) ? rcfe_pkg::CH_0 + tens :
                  (s.idx == 3'h4) ? rcfe_pkg::CH_0 + ones : rcfe_pkg::CH_0;
          if (s.idx == 3'h4) begin
            n.ost = O_TERM;
          end
        end
      end
      O_TERM: begin
        if (ofree) begin
          n.obd = term;
          n.obv = 1'b1;
          n.obe = 1'b1;
          n.ost = O_IDLE;
        end
      end
      default: n.ost = O_IDLE;
    endcase

    // clears; hardware sets still win over the status clear
    if (obclr) begin
      n.ost = O_IDLE;
      n.obv = 1'b0;
      n.obe = 1'b0;
    end
    if (iclr) begin
      n.mode = rcfe_pkg::MODE_RST;
      n.rcl = 1'b1;
      n.rloc = rcfe_pkg::LOC_PRESET;
      n.cab = 1'b1;
    end
    if (dev_clr) begin
      n.wp = 7'h00;
      n.rp = 7'h00;
      n.cnt = 7'h00;
      n.units = 7'h00;
      n.prv = 1'b0;
      n.prs = 1'b0;
      n.pst = P_IDLE;
    end
    n.rej = (rejclr ? 8'h00 : s.rej) | rej_set;
    n.rej[rcfe_pkg::LRN_REJ_BIT] = n.rej[rcfe_pkg::LRN_REJ_BIT] | lerr;

    // unbuffered: one message at most and no handshake until it is done
    n.ibr = (n.cnt < rcfe_pkg::IBUF_DEPTH) && !dev_clr &&
            !(n.mode[rcfe_pkg::MB_UNBUF] && (n.units != 7'h00 || n.pst != P_IDLE ||
              (n.mode[rcfe_pkg::MB_VALID] && !n.rfv)));
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      s <= '0;
      s.mode <= rcfe_pkg::MODE_RST;
      s.pst <= P_IDLE;
      s.ost <= O_IDLE;
      s.rfv <= 1'b1;
      s.ibr <= 1'b1;
    end else begin
      s <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign reg_rdata = s.rd;
  assign ib_ready = s.ibr;
  assign pr_data = s.prd;
  assign pr_valid = s.prv;
  assign pr_last = s.prl;
  assign pr_start = s.prs;
  assign rf_valid = s.rfv;
  assign ob_data = s.obd;
  assign ob_valid = s.obv;
  assign ob_eoi = s.obe;
  assign lrn_loc = s.loc;
  assign lrn_raddr = s.bi;
  assign lrn_we = s.lwe;
  assign lrn_waddr = s.lwa;
  assign lrn_wdata = s.lwd;
  assign preset_recall = s.rcl;
  assign recall_loc = s.rloc;
  assign comp_abort = s.cab;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  property p_term;
    ob_valid && ob_eoi |-> ob_data == (s.mode[rcfe_pkg::MB_TERM] ? 8'h0d : 8'h0a);
  endproperty
  a_term: assert property (p_term) else $error("terminator mismatch");

  property p_unbuf;
    s.mode[rcfe_pkg::MB_UNBUF] && s.units != 7'h00 |-> !ib_ready;
  endproperty
  a_unbuf: assert property (p_unbuf) else $error("unbuffered accepts past message");

  property p_start;
    pr_start |-> $past(!s.mode[rcfe_pkg::MB_VALID] || rf_valid) && $past(s.units) != 7'h00;
  endproperty
  a_start: assert property (p_start) else $error("message started unsettled");

  property p_settle;
    hw_change |=> !rf_valid;
  endproperty
  a_settle: assert property (p_settle) else $error("valid right after change");

  property p_rejrd;
    reg_rd && reg_addr == rcfe_pkg::REG_REJ && rej_set == 8'h00 && !ll_valid
      |=> s.rej == 8'h00;
  endproperty
  a_rejrd: assert property (p_rejrd) else $error("status survives read");

  property p_errmode;
    pr_start && $past(s.mode[rcfe_pkg::MB_ERR]) && $past(rej_set) == 8'h00
      && !$past(ll_valid) |-> s.rej == 8'h00;
  endproperty
  a_errmode: assert property (p_errmode) else $error("status kept at start");

  property p_iclr;
    reg_wr && reg_addr == rcfe_pkg::REG_CMD && reg_wdata[rcfe_pkg::CB_ICLR]
      |=> s.mode == 5'h00 && preset_recall && comp_abort && recall_loc == 7'h62 && !ob_valid;
  endproperty
  a_iclr: assert property (p_iclr) else $error("instrument clear incomplete");

  property p_devclr;
    dev_clr |=> s.cnt == 7'h00 && !pr_valid && !ob_valid && s.mode == 5'h00;
  endproperty
  a_devclr: assert property (p_devclr) else $error("bus clear incomplete");

  property p_stat;
    $past(s.ost == O_STAT && s.idx == 3'h0 && (!ob_valid || ob_ready)) && s.loc != 7'h63
      |-> ob_data == 8'h41 ##1 (ob_data == 8'h41 || ob_data == 8'h4d);
  endproperty
  a_stat: assert property (p_stat) else $error("status chars not AM");

  c_learn: cover property (s.ost == O_TERM && ob_ready ##1 ob_eoi);
  c_record: cover property (pr_start && s.mode[rcfe_pkg::MB_REC]);
  c_hold: cover property (ib_valid && !ib_ready && s.mode[rcfe_pkg::MB_UNBUF]);
  c_lerr: cover property (n.rej[rcfe_pkg::LRN_REJ_BIT] && !s.rej[rcfe_pkg::LRN_REJ_BIT]);

endmodule : rcfe_top
